// file: design/fka_function_action.sv
`include "fka_defines.svh"

module fka_function_action #(
    parameter int NUM_KEYS     = 12,
    parameter int UNIT_CYCLES  = `FKA_UNIT_CYCLES,
    parameter int ACK_CYCLES   = `FKA_ACK_CYCLES
) (
    // clock and reset
    input  wire logic                      REF_CLK,
    input  wire logic                      ARST_N,
    // configuration writes from the throttle and read back
    input  wire fka_pkg::fka_cfg_write_type CFG_WRITE,
    output logic [7:0]                     CFG_READ_DATA,
    // key and speed commands
    input  wire fka_pkg::fka_key_cmd_type   KEY_CMD,
    input  wire fka_pkg::fka_speed_cmd_type SPEED_CMD,
    // outputs
    output logic                           AUXILIARY_OUTPUT_ONE,
    output logic                           AUXILIARY_OUTPUT_TWO,
    output logic                           CRUISE_ENGAGED,
    output logic [7:0]                     CRUISE_SPEED,
    output logic                           HEADLIGHT_DIM,
    output logic                           MOTOR_ACK_PULSE
);
    timeunit 1ns;
    timeprecision 1ns;

    if (NUM_KEYS != 12 || UNIT_CYCLES < 1 || ACK_CYCLES < 1) begin : g_bad
        $error("fka_function_action: unsupported parameters");
    end

    // configuration storage
    logic [3:0] action_slot [NUM_KEYS];
    logic [7:0] aux_effect_period;
    logic [7:0] auxiliary_output_one_effect_select;
    logic [7:0] auxiliary_output_two_effect_select;
    logic [7:0] cruise_mode_select;
    logic [7:0] crossing_light_mode_select;

    wire [7:0] wr_idx = CFG_WRITE.index;
    wire       wr_slot = CFG_WRITE.valid &&
                         wr_idx >= `FKA_IDX_SLOT_FIRST &&
                         wr_idx <= `FKA_IDX_SLOT_LAST;
    wire [7:0] wr_slot_num = wr_idx - `FKA_IDX_SLOT_FIRST;

    genvar g;
    generate
        for (g = 0; g < NUM_KEYS; g++) begin : g_slot
            always_ff @(posedge REF_CLK or negedge ARST_N) begin
                if (!ARST_N)
                    action_slot[g] <= `FKA_ACT_NONE;
                else if (wr_slot && wr_slot_num == 8'(g))
                    action_slot[g] <= CFG_WRITE.data[3:0];
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aux_effect_period          <= `FKA_RST_AUX_PERIOD;
            auxiliary_output_one_effect_select         <= `FKA_RST_AUX_SELECT;
            auxiliary_output_two_effect_select         <= `FKA_RST_AUX_SELECT;
            cruise_mode_select         <= `FKA_RST_CRUISE_MODE;
            crossing_light_mode_select <= `FKA_RST_CROSSING_MODE;
        end else if (CFG_WRITE.valid) begin
            case (wr_idx)
                `FKA_IDX_AUX_PERIOD:    aux_effect_period  <= CFG_WRITE.data;
                `FKA_IDX_AUXILIARY_OUTPUT_ONE_SELECT:   auxiliary_output_one_effect_select <= CFG_WRITE.data;
                `FKA_IDX_AUXILIARY_OUTPUT_TWO_SELECT:   auxiliary_output_two_effect_select <= CFG_WRITE.data;
                `FKA_IDX_CRUISE_MODE:   cruise_mode_select <= CFG_WRITE.data;
                `FKA_IDX_CROSSING_MODE:
                    crossing_light_mode_select <= CFG_WRITE.data;
                default: ;
            endcase
        end
    end

    // read back, combinational on index
    wire [7:0] rd_slot_num = wr_idx - `FKA_IDX_SLOT_FIRST;
    wire       rd_is_slot  = wr_idx >= `FKA_IDX_SLOT_FIRST &&
                             wr_idx <= `FKA_IDX_SLOT_LAST;
    always_comb begin
        CFG_READ_DATA = 8'h00;
        if (rd_is_slot)
            CFG_READ_DATA = {4'h0, action_slot[rd_slot_num[3:0]]};
        else case (wr_idx)
            `FKA_IDX_AUX_PERIOD:    CFG_READ_DATA = aux_effect_period;
            `FKA_IDX_AUXILIARY_OUTPUT_ONE_SELECT:   CFG_READ_DATA = auxiliary_output_one_effect_select;
            `FKA_IDX_AUXILIARY_OUTPUT_TWO_SELECT:   CFG_READ_DATA = auxiliary_output_two_effect_select;
            `FKA_IDX_CRUISE_MODE:   CFG_READ_DATA = cruise_mode_select;
            `FKA_IDX_CROSSING_MODE: CFG_READ_DATA = crossing_light_mode_select;
            default:                CFG_READ_DATA = 8'h00;
        endcase
    end

    // motor acknowledge of slot writes
    logic [31:0] ack_count;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N)
            ack_count <= 32'h0;
        else if (wr_slot)
            ack_count <= 32'(ACK_CYCLES);
        else if (ack_count != 32'h0)
            ack_count <= ack_count - 32'h1;
    end
    assign MOTOR_ACK_PULSE = ack_count != 32'h0;

    // key decode
    wire        key_ok  = KEY_CMD.valid && KEY_CMD.key >= 4'h1 &&
                          KEY_CMD.key <= 4'(NUM_KEYS);
    wire [3:0]  key_num = KEY_CMD.key - 4'h1;
    wire [3:0]  action  = key_ok ? action_slot[key_num]
                                 : `FKA_ACT_NONE;
    // reserved codes match none of these, so nothing happens
    wire act_cruise = action == `FKA_ACT_CRUISE;
    wire act_auxiliary_output_one   = action == `FKA_ACT_TOGGLE_AUXILIARY_OUTPUT_ONE;
    wire act_auxiliary_output_two   = action == `FKA_ACT_TOGGLE_AUXILIARY_OUTPUT_TWO;
    wire act_dim    = action == `FKA_ACT_DIM_HEAD;
    wire act_flash  = action == `FKA_ACT_FLASH;

    // toggles
    logic auxiliary_output_one_on;
    logic auxiliary_output_two_on;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            auxiliary_output_one_on       <= 1'b0;
            auxiliary_output_two_on       <= 1'b0;
            HEADLIGHT_DIM <= 1'b0;
        end else begin
            auxiliary_output_one_on       <= auxiliary_output_one_on ^ act_auxiliary_output_one;
            auxiliary_output_two_on       <= auxiliary_output_two_on ^ act_auxiliary_output_two;
            HEADLIGHT_DIM <= HEADLIGHT_DIM ^ act_dim;
        end
    end

    // cruise control
    fka_pkg::fka_cruise_state_type cruise_state;
    fka_pkg::fka_cruise_state_type next_cruise_state;
    logic [7:0] last_speed;
    wire speed_change = SPEED_CMD.valid && SPEED_CMD.speed != last_speed;
    always_comb begin
        case (cruise_state)
            fka_pkg::FKA_CRUISE_OFF:
                next_cruise_state = act_cruise ? fka_pkg::FKA_CRUISE_HOLD
                                               : fka_pkg::FKA_CRUISE_OFF;
            fka_pkg::FKA_CRUISE_HOLD:
                next_cruise_state = (speed_change && !cruise_mode_select[0])
                    ? fka_pkg::FKA_CRUISE_OFF
                    : fka_pkg::FKA_CRUISE_HOLD;
            default: next_cruise_state = fka_pkg::FKA_CRUISE_OFF;
        endcase
    end
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cruise_state <= fka_pkg::FKA_CRUISE_OFF;
            last_speed   <= 8'h00;
            CRUISE_SPEED <= 8'h00;
        end else begin
            cruise_state <= next_cruise_state;
            if (SPEED_CMD.valid)
                last_speed <= SPEED_CMD.speed;
            if (act_cruise && cruise_state == fka_pkg::FKA_CRUISE_OFF)
                CRUISE_SPEED <= SPEED_CMD.valid ? SPEED_CMD.speed
                                                : last_speed;
            else if (speed_change && cruise_mode_select[0])
                CRUISE_SPEED <= SPEED_CMD.speed;
        end
    end
    assign CRUISE_ENGAGED = cruise_state == fka_pkg::FKA_CRUISE_HOLD;

    // effect timebase: period = max(aux_effect_period, 1) * 512 ms, 16 phases
    logic [31:0] unit_count;
    logic [7:0]  unit_index;
    logic [3:0]  phase;
    logic [3:0]  pwm;
    wire unit_tick = unit_count == 32'(UNIT_CYCLES / 16 - 1) ||
                     UNIT_CYCLES < 16;
    wire [7:0] period_units = aux_effect_period == 8'h00 ? 8'h01
                                                         : aux_effect_period;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            unit_count <= 32'h0;
            unit_index <= 8'h00;
            phase      <= 4'h0;
            pwm        <= 4'h0;
        end else begin
            pwm <= pwm + 4'h1;
            unit_count <= unit_tick ? 32'h0 : unit_count + 32'h1;
            if (unit_tick) begin
                unit_index <= (unit_index + 8'h1 >= period_units) ? 8'h00
                                                    : unit_index + 8'h1;
                if (unit_index + 8'h1 >= period_units)
                    phase <= phase + 4'h1;
            end
        end
    end
    wire dim_level = pwm < `FKA_DIM_STEPS;

    // crossing flash trigger
    logic [3:0] flash_left;
    wire period_wrap = unit_tick && unit_index + 8'h1 >= period_units &&
                       phase == 4'hf;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N)
            flash_left <= 4'h0;
        else if (act_flash)
            flash_left <= `FKA_FLASH_PERIODS;
        else if (period_wrap && flash_left != 4'h0)
            flash_left <= flash_left - 4'h1;
    end

    function automatic logic effect_level(input logic [7:0] sel,
                                          input logic [3:0] ph,
                                          input logic       dim,
                                          input logic       alt);
        logic [3:0] p;
        p = alt ? ph + 4'h8 : ph;
        case (sel)
            8'h00: effect_level = 1'b0;
            8'h01: effect_level = dim;
            8'h02: effect_level = 1'b1;
            8'h03: effect_level = p == 4'h0;
            8'h04: effect_level = p[3];
            8'h05: effect_level = p[3:1] == 3'h0;
            8'h06: effect_level = p[3] ? 1'b1 : dim;
            8'h07: effect_level = p[2] ^ p[0];
            8'h08: effect_level = p[3:2] == 2'h0 || p[3:2] == 2'h2;
            default: effect_level = 1'b0;
        endcase
    endfunction

    wire crossing = crossing_light_mode_select[0];
    wire auxiliary_output_one_lvl = effect_level(auxiliary_output_one_effect_select, phase, dim_level, 1'b0);
    wire auxiliary_output_two_lvl = effect_level(auxiliary_output_two_effect_select, phase, dim_level, 1'b1);
    wire flashing = flash_left != 4'h0;
    wire next_auxiliary_output_one = crossing ? (auxiliary_output_one_on && (flashing ? !phase[3] : auxiliary_output_one_lvl))
                              : (auxiliary_output_one_on && auxiliary_output_one_lvl);
    wire next_auxiliary_output_two = crossing ? (auxiliary_output_two_on && (flashing ? phase[3] : auxiliary_output_two_lvl))
                              : (auxiliary_output_two_on && auxiliary_output_two_lvl);
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            AUXILIARY_OUTPUT_ONE <= 1'b0;
            AUXILIARY_OUTPUT_TWO <= 1'b0;
        end else begin
            AUXILIARY_OUTPUT_ONE <= next_auxiliary_output_one;
            AUXILIARY_OUTPUT_TWO <= next_auxiliary_output_two;
        end
    end

endmodule // fka_function_action

// file: design/fka_defines.svh
`ifndef FKA_DEFINES_SVH
`define FKA_DEFINES_SVH

// configuration indices
`define FKA_IDX_SLOT_FIRST    8'h23
`define FKA_IDX_SLOT_LAST     8'h2e
`define FKA_IDX_AUX_PERIOD    8'h2f
`define FKA_IDX_AUXILIARY_OUTPUT_ONE_SELECT   8'h30
`define FKA_IDX_AUXILIARY_OUTPUT_TWO_SELECT   8'h31
`define FKA_IDX_CRUISE_MODE   8'h3f
`define FKA_IDX_CROSSING_MODE 8'h60

// reset values
`define FKA_RST_AUX_PERIOD    8'h03
`define FKA_RST_AUX_SELECT    8'h02
`define FKA_RST_CRUISE_MODE   8'h00
`define FKA_RST_CROSSING_MODE 8'h00

// action codes
`define FKA_ACT_NONE          4'h0
`define FKA_ACT_CRUISE        4'h1
`define FKA_ACT_TOGGLE_AUXILIARY_OUTPUT_ONE   4'h3
`define FKA_ACT_TOGGLE_AUXILIARY_OUTPUT_TWO   4'h4
`define FKA_ACT_DIM_HEAD      4'h7
`define FKA_ACT_FLASH         4'hf

// effect codes
`define FKA_FX_OFF            4'h0
`define FKA_FX_DIM            4'h1
`define FKA_FX_FULL           4'h2
`define FKA_FX_LAST_ANIM      4'h8

// timing: effect period unit is 512 ms
`define FKA_CLK_HZ            100000000
`define FKA_PERIOD_UNIT_MS    512
`define FKA_UNIT_CYCLES       (`FKA_CLK_HZ / 1000 * `FKA_PERIOD_UNIT_MS)
// dim level: 1 of 16 pwm steps, about six percent
`define FKA_DIM_STEPS         4'h1
// motor acknowledge pulse, 50 ms
`define FKA_ACK_MS            50
`define FKA_ACK_CYCLES        (`FKA_CLK_HZ / 1000 * `FKA_ACK_MS)
// crossing flash run length, in effect periods
`define FKA_FLASH_PERIODS     4'h8

`endif

// file: design/fka_pkg.sv
package fka_pkg;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic       valid;
        logic [7:0] index;
        logic [7:0] data;
    } fka_cfg_write_type;

    typedef struct packed {
        logic       valid;
        logic [3:0] key;
    } fka_key_cmd_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] speed;
    } fka_speed_cmd_type;

    typedef enum logic [1:0] {
        FKA_CRUISE_OFF,
        FKA_CRUISE_HOLD
    } fka_cruise_state_type;
endpackage

// file: verification/fka_function_action_asserts.sv
module fka_function_action_chk (
    // clock and reset
    input wire logic                       REF_CLK,
    input wire logic                       ARST_N,
    // commands and read
    input wire fka_pkg::fka_cfg_write_type CFG_WRITE,
    input wire logic [7:0]                 CFG_READ_DATA,
    input wire fka_pkg::fka_key_cmd_type   KEY_CMD,
    input wire fka_pkg::fka_speed_cmd_type SPEED_CMD,
    // outputs
    input wire logic                       AUXILIARY_OUTPUT_ONE,
    input wire logic                       AUXILIARY_OUTPUT_TWO,
    input wire logic                       CRUISE_ENGAGED,
    input wire logic [7:0]                 CRUISE_SPEED,
    input wire logic                       HEADLIGHT_DIM,
    input wire logic                       MOTOR_ACK_PULSE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    logic [7:0] sel1;
    logic [7:0] sel2;
    logic [7:0] crz;
    logic [7:0] xm;
    wire        wr      = CFG_WRITE.valid;
    wire  [7:0] ix      = CFG_WRITE.index;
    wire        slot_wr = wr && ix >= 8'h23 && ix <= 8'h2e;
    wire        dk1     = xm == 8'h00 && (sel1 == 8'h00 || sel1 > 8'h08);
    wire        dk2     = xm == 8'h00 && (sel2 == 8'h00 || sel2 > 8'h08);
    // shadows of the selects and modes
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel1 <= 8'h02;
            sel2 <= 8'h02;
            crz  <= 8'h00;
            xm   <= 8'h00;
        end else if (wr) begin
            sel1 <= (ix == 8'h30) ? CFG_WRITE.data : sel1;
            sel2 <= (ix == 8'h31) ? CFG_WRITE.data : sel2;
            crz  <= (ix == 8'h3f) ? CFG_WRITE.data : crz;
            xm   <= (ix == 8'h60) ? CFG_WRITE.data : xm;
        end
    end
    chk_ack_on_write: assert property (
        slot_wr |=> MOTOR_ACK_PULSE)
        else $error("no motor pulse after slot write");
    chk_ack_has_cause: assert property (
        $rose(MOTOR_ACK_PULSE) |-> $past(slot_wr))
        else $error("motor pulse without slot write");
    chk_slot_keeps_code: assert property (
        slot_wr ##1 ix == $past(ix) |->
        CFG_READ_DATA == {4'h0, $past(CFG_WRITE.data[3:0])})
        else $error("slot does not hold written code");
    chk_cruise_drop_mode: assert property (
        CRUISE_ENGAGED && crz == 8'h00 && SPEED_CMD.valid &&
        SPEED_CMD.speed != CRUISE_SPEED |=> !CRUISE_ENGAGED)
        else $error("cruise kept after speed change in mode 0");
    chk_cruise_track_mode: assert property (
        CRUISE_ENGAGED && crz == 8'h01 && SPEED_CMD.valid |=>
        CRUISE_ENGAGED && CRUISE_SPEED == $past(SPEED_CMD.speed))
        else $error("cruise does not track in mode 1");
    chk_cruise_speed_hold: assert property (
        CRUISE_ENGAGED && !SPEED_CMD.valid |=> $stable(CRUISE_SPEED))
        else $error("held cruise speed moved");
    chk_engage_has_key: assert property (
        $rose(CRUISE_ENGAGED) |-> $past(KEY_CMD.valid))
        else $error("cruise engaged without key");
    chk_dim_holds_state: assert property (
        !KEY_CMD.valid |=> $stable(HEADLIGHT_DIM))
        else $error("headlight dim changed without key");
    chk_auxiliary_output_one_stays_dark: assert property (
        dk1 [*3] |-> !AUXILIARY_OUTPUT_ONE)
        else $error("aux one lit with dark effect");
    chk_auxiliary_output_two_stays_dark: assert property (
        dk2 && $past(dk2) && $past(dk2, 2) |-> !AUXILIARY_OUTPUT_TWO)
        else $error("aux two lit with dark effect");
    cover property (slot_wr);
    cover property ($fell(CRUISE_ENGAGED));
    cover property (CRUISE_ENGAGED && crz == 8'h01 && SPEED_CMD.valid);
endmodule // fka_function_action_chk

bind fka_function_action fka_function_action_chk u_chk (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .CFG_WRITE(CFG_WRITE),
    .CFG_READ_DATA(CFG_READ_DATA), .KEY_CMD(KEY_CMD), .SPEED_CMD(SPEED_CMD),
    .AUXILIARY_OUTPUT_ONE(AUXILIARY_OUTPUT_ONE),
    .AUXILIARY_OUTPUT_TWO(AUXILIARY_OUTPUT_TWO),
    .CRUISE_ENGAGED(CRUISE_ENGAGED), .CRUISE_SPEED(CRUISE_SPEED),
    .HEADLIGHT_DIM(HEADLIGHT_DIM), .MOTOR_ACK_PULSE(MOTOR_ACK_PULSE)
);

// file: verification/fka_throttle_model.sv
module fka_throttle_model (
    // clock
    input  wire logic                 ref_clk,
    // commands toward the decoder
    output fka_pkg::fka_cfg_write_type  cfg_write,
    output fka_pkg::fka_key_cmd_type    key_cmd,
    output fka_pkg::fka_speed_cmd_type  speed_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cfg_write = '0;
        key_cmd   = '0;
        speed_cmd = '0;
    end
    // one-cycle write; idle data shows the inverse so stale values never match
    task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        cfg_write <= '{1'b1, idx, d};
        @(posedge ref_clk);
        cfg_write <= '{1'b0, idx, ~d};
    endtask
    task automatic rd(input logic [7:0] idx);
        @(posedge ref_clk);
        cfg_write.index <= idx;
    endtask
    task automatic key(input logic [3:0] k);
        @(posedge ref_clk);
        key_cmd <= '{1'b1, k};
        @(posedge ref_clk);
        key_cmd <= '{1'b0, ~k};
    endtask
    task automatic speed(input logic [7:0] s);
        @(posedge ref_clk);
        speed_cmd <= '{1'b1, s};
        @(posedge ref_clk);
        speed_cmd <= '{1'b0, ~s};
    endtask
endmodule // fka_throttle_model

// file: verification/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                       ref_clk;
    logic                       arst_n;
    int                         miscompares = 0;
    int                         cmp_count = 0;
    fka_pkg::fka_cfg_write_type cfg_write;
    fka_pkg::fka_key_cmd_type   key_cmd;
    fka_pkg::fka_speed_cmd_type speed_cmd;
    logic [7:0]                 rd_data;
    logic                       auxiliary_output_one;
    logic                       auxiliary_output_two;
    logic                       cr_on;
    logic [7:0]                 cr_spd;
    logic                       hd_dim;
    logic                       ack;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    fka_throttle_model u_thr (.ref_clk(ref_clk), .cfg_write(cfg_write),
        .key_cmd(key_cmd), .speed_cmd(speed_cmd));
    fka_function_action #(.UNIT_CYCLES(32), .ACK_CYCLES(4)) u_dut (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .CFG_WRITE(cfg_write),
        .CFG_READ_DATA(rd_data), .KEY_CMD(key_cmd), .SPEED_CMD(speed_cmd),
        .AUXILIARY_OUTPUT_ONE(auxiliary_output_one), .AUXILIARY_OUTPUT_TWO(auxiliary_output_two),
        .CRUISE_ENGAGED(cr_on), .CRUISE_SPEED(cr_spd),
        .HEADLIGHT_DIM(hd_dim), .MOTOR_ACK_PULSE(ack));
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        u_thr.rd(i);
        #1;
        chk("cfg_read", e, rd_data);
    endtask
    task automatic press(input logic [3:0] k);
        u_thr.key(k);
        wait_n(2);
    endtask
    task automatic watch(input int c, output int n1, output int n2);
        n1 = 0;
        n2 = 0;
        repeat (c) begin
            wait_n(1);
            n1 += int'(auxiliary_output_one === 1'b1);
            n2 += int'(auxiliary_output_two === 1'b1 && auxiliary_output_one !== 1'b1);
        end
    endtask
    task automatic t_reset;
        rdc(8'h2f, 8'h03);
        rdc(8'h30, 8'h02);
        rdc(8'h31, 8'h02);
        rdc(8'h3f, 8'h00);
        rdc(8'h60, 8'h00);
        rdc(8'h32, 8'h00);
        for (int i = 0; i < 12; i++) rdc(8'h23 + 8'(i), 8'h00);
    endtask
    task automatic t_ack;
        int n = 0;
        u_thr.cfg(8'h23, 8'hf3);
        #1;
        while (ack === 1'b1 && n < 20) begin
            n++;
            wait_n(1);
        end
        chk("ack_len", 8'h04, 8'(n));
        rdc(8'h23, 8'h03);
        u_thr.cfg(8'h24, 8'h04);
    endtask
    task automatic t_toggle;
        press(4'h1);
        chk("auxiliary_output_one", 8'h01, 8'(auxiliary_output_one));
        chk("auxiliary_output_two", 8'h00, 8'(auxiliary_output_two));
        press(4'h1);
        chk("auxiliary_output_one", 8'h00, 8'(auxiliary_output_one));
        press(4'h2);
        chk("auxiliary_output_two", 8'h01, 8'(auxiliary_output_two));
        press(4'h1);
        chk("auxiliary_output_one", 8'h01, 8'(auxiliary_output_one));
    endtask
    task automatic t_reserved;
        logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h8, 4'he};
        foreach (codes[i]) begin
            u_thr.cfg(8'h25, {4'h0, codes[i]});
            press(4'h3);
            chk("auxiliary_output_one", 8'h01, 8'(auxiliary_output_one));
            chk("auxiliary_output_two", 8'h01, 8'(auxiliary_output_two));
            chk("head_dim", 8'h00, 8'(hd_dim));
            chk("cruise", 8'h00, 8'(cr_on));
        end
    endtask
    task automatic t_levels;
        logic [7:0] dk [3] = '{8'h00, 8'h09, 8'h0f};
        int n1;
        int n2;
        foreach (dk[i]) begin
            u_thr.cfg(8'h30, dk[i]);
            u_thr.cfg(8'h31, dk[i]);
            wait_n(3);
            chk("auxiliary_output_one_dark", 8'h00, 8'(auxiliary_output_one));
            chk("auxiliary_output_two_dark", 8'h00, 8'(auxiliary_output_two));
        end
        u_thr.cfg(8'h31, 8'h02);
        u_thr.cfg(8'h30, 8'h01);
        watch(160, n1, n2);
        chk("auxiliary_output_one_dim", 8'h01, 8'(n1 > 0 && n1 < 40));
        u_thr.cfg(8'h2f, 8'h01);
        for (int c = 3; c <= 8; c++) begin
            u_thr.cfg(8'h30, 8'(c));
            watch(64, n1, n2);
            chk("auxiliary_output_one_anim", 8'h01, 8'(n1 > 0 && n1 < 64));
        end
        u_thr.cfg(8'h30, 8'h02);
    endtask
    task automatic t_head_cruise;
        u_thr.cfg(8'h26, 8'h07);
        press(4'h4);
        chk("head_dim", 8'h01, 8'(hd_dim));
        press(4'h4);
        chk("head_dim", 8'h00, 8'(hd_dim));
        u_thr.speed(8'h0a);
        u_thr.cfg(8'h27, 8'h01);
        press(4'h5);
        chk("cruise", 8'h01, 8'(cr_on));
        chk("cruise_speed", 8'h0a, cr_spd);
        u_thr.speed(8'h14);
        wait_n(1);
        chk("cruise", 8'h00, 8'(cr_on));
        u_thr.cfg(8'h3f, 8'h01);
        press(4'h5);
        u_thr.speed(8'h1e);
        wait_n(1);
        chk("cruise", 8'h01, 8'(cr_on));
        chk("cruise_speed", 8'h1e, cr_spd);
    endtask
    task automatic t_flash;
        int n1;
        int n2;
        u_thr.cfg(8'h60, 8'h01);
        u_thr.cfg(8'h28, 8'h0f);
        press(4'h6);
        watch(300, n1, n2);
        chk("flash_auxiliary_output_one", 8'h01, 8'(n1 > 0 && n1 < 300));
        chk("flash_auxiliary_output_two", 8'h01, 8'(n2 > 0));
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_ack();
        t_toggle();
        t_reserved();
        t_levels();
        t_head_cruise();
        t_flash();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule // testbench
